/* hw/gtu_pkg.sv */
// Constants and types shared by the general timer unit
package gtu_pkg;
    // Bus data width, decoded address bits and timer width
    localparam int GTU_DW = 32;
    localparam int GTU_AW = 8;
    localparam int GTU_TW = 16;
    // Register offsets; per-timer registers sit at base plus four times the index
    localparam logic [7:0] GTU_OFF_CTRL = 8'h00;
    localparam logic [7:0] GTU_OFF_CNT  = 8'h10;
    localparam logic [7:0] GTU_OFF_AUXR = 8'h20;
    localparam logic [7:0] GTU_OFF_STAT = 8'h30;
    localparam logic [7:0] GTU_OFF_MASK = 8'h34;
    // Control field positions
    localparam int GTU_F_MODE  = 0;
    localparam int GTU_F_PRE   = 2;
    localparam int GTU_F_RUN   = 5;
    localparam int GTU_F_DOWN  = 6;
    localparam int GTU_F_DPIN  = 7;
    localparam int GTU_F_CHAIN = 8;
    localparam int GTU_F_LEDGE = 9;
    localparam int GTU_F_ACT   = 11;
    localparam int GTU_F_CEDGE = 13;
    localparam int GTU_F_EXT   = 15;
    localparam int GTU_F_LATCH = 16;
    localparam int GTU_F_LKEY  = 17;
    localparam int GTU_CTRL_W  = 16;
    // Reset values
    localparam logic [15:0] GTU_CTRL_RST  = 16'h2000;
    localparam logic [15:0] GTU_CNT_RST   = 16'h0000;
    localparam logic [15:0] GTU_AUXR_RST  = 16'h0000;
    localparam logic        GTU_LATCH_RST = 1'b0;
    // Finest step as a power of two of CPU cycles, prescaler select width
    localparam int GTU_RES_LOG = 3;
    localparam int GTU_PRE_W   = 3;
    localparam int GTU_DIV_W   = GTU_RES_LOG + (1 << GTU_PRE_W) - 1;
    // Operating modes
    typedef enum logic [1:0] {
        GTU_M_TIMER   = 2'h0,
        GTU_M_GATED   = 2'h1,
        GTU_M_COUNTER = 2'h2,
        GTU_M_INCR    = 2'h3
    } gtu_mode_t;
    // Action of an auxiliary timer on the core timer
    typedef enum logic [1:0] {
        GTU_ACT_NONE    = 2'h0,
        GTU_ACT_RELOAD  = 2'h1,
        GTU_ACT_CAPTURE = 2'h2,
        GTU_ACT_RSVD    = 2'h3
    } gtu_act_t;
endpackage : gtu_pkg

/* hw/gtu_pin_sync.sv */
// Two-stage synchroniser for the timer pins with a delayed copy for edges
`timescale 1ns/10ps
module gtu_pin_sync
#(
    parameter int N = 2
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Pins and synchronised levels
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] lvl,
    output logic      [N-1:0] prv
);
    logic [N-1:0] meta_r;

    // Only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            lvl    <= '0;
            prv    <= '0;
        end
        else
        begin
            meta_r <= pin_in;
            lvl    <= meta_r;
            prv    <= lvl;
        end
    end
endmodule : gtu_pin_sync

/* hw/gtu_timer.sv */
// One up/down timer with load priority and wrap pulse
`timescale 1ns/10ps
module gtu_timer
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Step control
    input  wire logic         count_en,
    input  wire logic         down,
    // Load port
    input  wire logic         load_en,
    input  wire logic [W-1:0] load_val,
    // State
    output logic      [W-1:0] cnt,
    output logic              ovf
);
    if (W < 2 || W > 16) begin : g_chk
        $error("W must be 2 to 16");
    end

    // Load beats counting; wrap raises a one-cycle pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= W'(16'h0000);
            ovf <= 1'b0;
        end
        else
        begin
            ovf <= 1'b0;
            if (load_en)
            begin
                cnt <= load_val;
            end
            else if (count_en)
            begin
                cnt <= down ? cnt - 1'b1 : cnt + 1'b1;
                ovf <= down ? (cnt == '0) : (&cnt);
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_sw_prio;
        load_en |=> cnt == $past(load_val);
    endproperty
    a_sw_prio: assert property (p_sw_prio) else $error("load lost");

    property p_res;
        count_en |=> !count_en [*7];
    endproperty
    a_res: assert property (p_res) else $error("steps too close");

    property p_step;
        count_en && !load_en |=> (cnt - $past(cnt)) == ($past(down) ? {W{1'b1}} : W'(1));
    endproperty
    a_step: assert property (p_step) else $error("wrong step");

    property p_wrap;
        ovf |-> (cnt == '0 || cnt == {W{1'b1}});
    endproperty
    a_wrap: assert property (p_wrap) else $error("pulse without wrap");
endmodule : gtu_timer

/* hw/gtu_top.sv */
// General timer unit: core timer, auxiliary timers and AHB-Lite registers
`timescale 1ns/10ps
module gtu_top
#(
    parameter int NUM_TMR = 3
)
(
    // Clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [gtu_pkg::GTU_DW-1:0]   hwdata,
    input  wire logic                         hready,
    output logic      [gtu_pkg::GTU_DW-1:0]   hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // Timer pins
    input  wire logic [NUM_TMR-1:0]           count_input_pin,
    input  wire logic [NUM_TMR-1:0]           direction_input_pin,
    // Outputs to the chip
    output logic                              core_ovf_pulse,
    output logic                              core_toggle_latch,
    output logic                              irq
);
    import gtu_pkg::*;

    if (NUM_TMR < 2 || NUM_TMR > 4) begin : g_chk
        $error("NUM_TMR must be 2 to 4");
    end

    // ****************************************
    // Bus slave
    // ****************************************
    logic                acc;
    logic                wr_r;
    logic                rd_wait_r;
    logic [GTU_AW-1:0]   adr_r;
    logic [GTU_DW-1:0]   hrdata_r;
    logic [GTU_DW-1:0]   rd_mux;

    assign acc = hsel & htrans[1] & hready;

    // Address phase capture; reads take one wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_r      <= 1'b0;
            rd_wait_r <= 1'b0;
            adr_r     <= '0;
        end
        else
        begin
            wr_r      <= acc & hwrite;
            rd_wait_r <= acc & ~hwrite;
            if (acc)
            begin
                adr_r <= haddr[GTU_AW-1:0];
            end
        end
    end

    // Read data sampled in the wait state, so a preceding write is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= '0;
        end
        else if (rd_wait_r)
        begin
            hrdata_r <= rd_mux;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = ~rd_wait_r;
    assign hresp     = 1'b0;

    // ****************************************
    // Registers
    // ****************************************
    logic [GTU_CTRL_W-1:0] ctrl_r [NUM_TMR];
    logic [GTU_TW-1:0]     auxr_r [NUM_TMR];
    logic [GTU_TW-1:0]     cnt    [NUM_TMR];
    logic [GTU_TW-1:0]     ld_val [NUM_TMR];
    logic [NUM_TMR-1:0]    wr_ctrl;
    logic [NUM_TMR-1:0]    wr_cnt;
    logic [NUM_TMR-1:0]    wr_auxr;
    logic [NUM_TMR-1:0]    stat_r;
    logic [NUM_TMR-1:0]    mask_r;
    logic [NUM_TMR-1:0]    ovf;
    logic [NUM_TMR-1:0]    count_en;
    logic [NUM_TMR-1:0]    down;
    logic [NUM_TMR-1:0]    ld_en;
    logic [NUM_TMR-1:0]    rld_req;
    logic [NUM_TMR-1:0]    cap_req;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  lat_r;
    logic                  lat_wr;
    logic                  lat_rise;
    logic                  lat_fall;
    logic                  rld_any;
    logic [GTU_TW-1:0]     rld_val;

    // Write strobes in the data phase
    for (genvar i = 0; i < NUM_TMR; i++)
    begin : g_dec
        assign wr_ctrl[i] = wr_r && adr_r == GTU_OFF_CTRL + 8'(4 * i);
        assign wr_cnt[i]  = wr_r && adr_r == GTU_OFF_CNT + 8'(4 * i);
        assign wr_auxr[i] = wr_r && adr_r == GTU_OFF_AUXR + 8'(4 * i);
    end
    assign wr_stat = wr_r && adr_r == GTU_OFF_STAT;
    assign wr_mask = wr_r && adr_r == GTU_OFF_MASK;

    // Control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int k = 0; k < NUM_TMR; k++)
            begin
                ctrl_r[k] <= GTU_CTRL_RST;
            end
        end
        else
        begin
            for (int k = 0; k < NUM_TMR; k++)
            begin
                if (wr_ctrl[k])
                begin
                    ctrl_r[k] <= hwdata[GTU_CTRL_W-1:0];
                end
            end
        end
    end

    // Reload/capture registers; software beats a capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int k = 0; k < NUM_TMR; k++)
            begin
                auxr_r[k] <= GTU_AUXR_RST;
            end
        end
        else
        begin
            for (int k = 0; k < NUM_TMR; k++)
            begin
                if (wr_auxr[k])
                begin
                    auxr_r[k] <= hwdata[GTU_TW-1:0];
                end
                else if (cap_req[k])
                begin
                    auxr_r[k] <= cnt[0];
                end
            end
        end
    end

    // Core toggle latch: keyed write only, else toggles on core wrap
    assign lat_wr   = wr_ctrl[0] & hwdata[GTU_F_LKEY];
    assign lat_rise = ovf[0] & ~lat_r & ~lat_wr;
    assign lat_fall = ovf[0] & lat_r & ~lat_wr;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lat_r <= GTU_LATCH_RST;
        end
        else if (lat_wr)
        begin
            lat_r <= hwdata[GTU_F_LATCH];
        end
        else if (ovf[0])
        begin
            lat_r <= ~lat_r;
        end
    end

    // Sticky flags, write one to clear, a new wrap wins; mask register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_r <= '0;
            mask_r <= '0;
        end
        else
        begin
            stat_r <= (stat_r & ~({NUM_TMR{wr_stat}} & hwdata[NUM_TMR-1:0])) | ovf;
            if (wr_mask)
            begin
                mask_r <= hwdata[NUM_TMR-1:0];
            end
        end
    end

    assign irq               = |(stat_r & mask_r);
    assign core_ovf_pulse    = ovf[0];
    assign core_toggle_latch = lat_r;

    // Read multiplexer, unmapped reads return zero
    always_comb
    begin
        rd_mux = '0;
        for (int k = 0; k < NUM_TMR; k++)
        begin
            if (adr_r == GTU_OFF_CTRL + 8'(4 * k))
                rd_mux[GTU_CTRL_W-1:0] = ctrl_r[k];
            if (adr_r == GTU_OFF_CNT + 8'(4 * k))
                rd_mux[GTU_TW-1:0] = cnt[k];
            if (adr_r == GTU_OFF_AUXR + 8'(4 * k))
                rd_mux[GTU_TW-1:0] = auxr_r[k];
        end
        if (adr_r == GTU_OFF_CTRL)
            rd_mux[GTU_F_LATCH] = lat_r;
        if (adr_r == GTU_OFF_STAT)
            rd_mux[NUM_TMR-1:0] = stat_r;
        if (adr_r == GTU_OFF_MASK)
            rd_mux[NUM_TMR-1:0] = mask_r;
    end

    // ****************************************
    // Timing base and pins
    // ****************************************
    logic [GTU_DIV_W-1:0] div_r;
    logic                 base_tick;
    logic [NUM_TMR-1:0]   cin_lvl;
    logic [NUM_TMR-1:0]   cin_prv;
    logic [NUM_TMR-1:0]   din_lvl;
    logic [NUM_TMR-1:0]   din_prv;

    // Free-running prescaler; base tick every eight cycles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end
    assign base_tick = &div_r[GTU_RES_LOG-1:0];

    gtu_pin_sync #(.N(2 * NUM_TMR)) gtu_pin_sync_i (
        .clk    (hclk),
        .rst_n  (hresetn),
        .pin_in ({direction_input_pin, count_input_pin}),
        .lvl    ({din_lvl, cin_lvl}),
        .prv    ({din_prv, cin_prv})
    );

    // Core reload source, lowest auxiliary index wins
    always_comb
    begin
        rld_any = 1'b0;
        rld_val = auxr_r[0];
        for (int j = NUM_TMR - 1; j > 0; j--)
        begin
            if (rld_req[j])
            begin
                rld_any = 1'b1;
                rld_val = auxr_r[j];
            end
        end
    end

    // ****************************************
    // Timers
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    for (genvar i = 0; i < NUM_TMR; i++)
    begin : g_tmr
        gtu_mode_t            mode;
        gtu_act_t             act;
        logic [GTU_PRE_W-1:0] pre;
        logic [GTU_DIV_W-1:0] pmask;
        logic                 run;
        logic                 chain;
        logic                 pre_tick;
        logic                 cev;
        logic                 qstep;
        logic                 lev;
        logic                 ev;
        logic                 trig;
        logic                 pend_r;
        logic                 qdn_r;

        // Field decode per timer
        assign mode  = gtu_mode_t'(ctrl_r[i][GTU_F_MODE +: 2]);
        assign pre   = ctrl_r[i][GTU_F_PRE +: GTU_PRE_W];
        assign run   = ctrl_r[i][GTU_F_RUN];
        assign chain = (i != 0) && ctrl_r[i][GTU_F_CHAIN];
        assign act   = (i == 0) ? GTU_ACT_NONE : gtu_act_t'(ctrl_r[i][GTU_F_ACT +: 2]);
        assign pmask = GTU_DIV_W'(((1 << GTU_RES_LOG) << pre) - 1);
        assign pre_tick = (div_r & pmask) == pmask;

        // Pin edges, quadrature steps and latch transitions
        assign cev = (ctrl_r[i][GTU_F_CEDGE] & cin_lvl[i] & ~cin_prv[i])
                   | (ctrl_r[i][GTU_F_CEDGE + 1] & ~cin_lvl[i] & cin_prv[i]);
        assign qstep = (cin_lvl[i] ^ cin_prv[i]) | (din_lvl[i] ^ din_prv[i]);
        assign lev = (ctrl_r[i][GTU_F_LEDGE] & lat_rise)
                   | (ctrl_r[i][GTU_F_LEDGE + 1] & lat_fall);
        assign ev = chain ? lev
                  : (mode == GTU_M_COUNTER) ? cev
                  : (mode == GTU_M_INCR) ? qstep : 1'b0;

        // Events wait for the next base tick; a new event beats the consume
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                pend_r <= 1'b0;
                qdn_r  <= 1'b0;
            end
            else if (ev)
            begin
                pend_r <= 1'b1;
                qdn_r  <= ~(cin_lvl[i] ^ din_prv[i]);
            end
            else if (base_tick)
            begin
                pend_r <= 1'b0;
            end
        end

        // Step enable and direction
        assign count_en[i] = run & ((chain || mode == GTU_M_COUNTER || mode == GTU_M_INCR)
                           ? pend_r & base_tick
                           : pre_tick & (mode == GTU_M_TIMER | cin_lvl[i]));
        assign down[i] = (mode == GTU_M_INCR && !chain)
                       ? qdn_r ^ ctrl_r[i][GTU_F_DOWN]
                       : ctrl_r[i][GTU_F_DOWN] ^ (ctrl_r[i][GTU_F_DPIN] & din_lvl[i]);

        // Reload or capture of the core timer
        assign trig       = ctrl_r[i][GTU_F_EXT] ? cev : lev;
        assign rld_req[i] = trig & (act == GTU_ACT_RELOAD);
        assign cap_req[i] = trig & (act == GTU_ACT_CAPTURE);
        assign ld_en[i]   = wr_cnt[i] | ((i == 0) & rld_any);
        assign ld_val[i]  = wr_cnt[i] ? hwdata[GTU_TW-1:0] : rld_val;

        gtu_timer #(.W(GTU_TW)) gtu_timer_i (
            .clk      (hclk),
            .rst_n    (hresetn),
            .count_en (count_en[i]),
            .down     (down[i]),
            .load_en  (ld_en[i]),
            .load_val (ld_val[i]),
            .cnt      (cnt[i]),
            .ovf      (ovf[i])
        );

        property p_gate;
            run && !chain && mode == GTU_M_GATED && !cin_lvl[i] |-> !count_en[i];
        endproperty
        a_gate: assert property (p_gate) else $error("gated timer ran");

        property p_timer;
            run && !chain && mode == GTU_M_TIMER && pre_tick |-> count_en[i];
        endproperty
        a_timer: assert property (p_timer) else $error("tick missed");

        property p_chain;
            run && chain && lev |-> ##[1:8] count_en[i];
        endproperty
        a_chain: assert property (p_chain) else $error("chain step lost");
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_lat_tog;
        ovf[0] && !lat_wr |=> lat_r != $past(lat_r);
    endproperty
    a_lat_tog: assert property (p_lat_tog) else $error("latch did not toggle");

    property p_lat_keep;
        wr_ctrl[0] && !hwdata[GTU_F_LKEY] && !ovf[0] |=> $stable(lat_r);
    endproperty
    a_lat_keep: assert property (p_lat_keep) else $error("latch disturbed");

    property p_stat_set;
        |ovf |=> (stat_r & $past(ovf)) == $past(ovf);
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("flag not set");

    property p_reload;
        rld_any && !wr_cnt[0] |=> cnt[0] == $past(rld_val);
    endproperty
    a_reload: assert property (p_reload) else $error("reload lost");

    property p_ovf_out;
        core_ovf_pulse |-> cnt[0] == '0 || cnt[0] == {GTU_TW{1'b1}};
    endproperty
    a_ovf_out: assert property (p_ovf_out) else $error("bad overflow pulse");

    property p_rd;
        acc && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read timing");

    c_ovf: cover property (core_ovf_pulse);
    c_chain: cover property (g_tmr[1].chain && count_en[1]);
    c_cap: cover property (|cap_req);
    c_irq: cover property ($rose(irq));
endmodule : gtu_top

/* tb/gtu_pins_model.sv */
// Behavioural model of the event pins and the incremental position sensor
`timescale 1ns/10ps
module gtu_pins_model
(
    // Clock
    input  wire logic       clk,
    // Pins toward the timer unit
    output logic      [2:0] cnt_pin,
    output logic      [2:0] dir_pin
);
    // ****************************************
    // Pin drivers
    // ****************************************
    // Lines rest low between bursts
    initial
    begin
        cnt_pin = 3'h0;
        dir_pin = 3'h0;
    end

    // Event source on lane 1: eight cycles high, nine low between pulses
    task automatic evt(input int n);
        repeat (n)
        begin
            @(posedge clk);
            cnt_pin[1] <= 1'b1;
            repeat (8) @(posedge clk);
            cnt_pin[1] <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : evt

    // Sensor on lane 2: track A leads track B, one step per twelve cycles
    task automatic quad(input int n);
        repeat (n)
        begin
            repeat (12) @(posedge clk);
            cnt_pin[2] <= ~dir_pin[2];
            dir_pin[2] <= cnt_pin[2];
        end
    endtask : quad
endmodule : gtu_pins_model

/* tb/general_purpose_timer_unit_tb.sv */
// Self-checking bench of the general timer unit
`timescale 1ns/10ps
module general_purpose_timer_unit_tb;
    import gtu_pkg::*;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ovf;
    logic        latch;
    logic        irq;
    logic        rd_ph   = 1'b0;
    logic [2:0]  cpin;
    logic [2:0]  dpin;
    logic [31:0] exp_q[$];
    logic [31:0] me;
    logic [31:0] seed    = 32'h5;
    logic [15:0] r;
    int          bad_count  = 0;
    int          n_compared = 0;

    // Clock of 8 ns
    always #4 hclk = ~hclk;

    gtu_top #(.NUM_TMR(3)) gtu_top_i
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_input_pin(cpin), .direction_input_pin(dpin),
        .core_ovf_pulse(ovf), .core_toggle_latch(latch), .irq(irq)
    );

    gtu_pins_model gtu_pins_model_i (.clk(hclk), .cnt_pin(cpin), .dir_pin(dpin));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Bounded wait for ready (o=0) or the core wrap pulse (o=1)
    task automatic wt(input bit o);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge hclk);
            if ((o ? ovf : hreadyout) === 1'b1)
                return;
        end
        bad_count++;
        $display("CHECK FAILED wait exp 1 seen 0");
        end_of_test();
    endtask : wt

    // One single AHB-Lite transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wt(1'b0);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt(1'b0);
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic chk(input string nm, input logic e, input logic s);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %b seen %b", nm, e, s);
        end
    endtask : chk

    // Read data checker: oldest note against each completed read
    always @(posedge hclk)
    begin
        if (rd_ph && hreadyout === 1'b1)
        begin
            me = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
            n_compared++;
            if (hrdata !== me)
            begin
                bad_count++;
                $display("CHECK FAILED hrdata exp %h seen %h", me, hrdata);
            end
            chk("hresp", 1'b0, hresp);
        end
        rd_ph <= (hsel & htrans[1] & hreadyout & ~hwrite) | (rd_ph & ~hreadyout);
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset state and an unmapped word
        rd(GTU_OFF_CTRL, {16'h0, GTU_CTRL_RST});
        rd(GTU_OFF_STAT, 32'h0);
        rd(8'hfc, 32'h0);
        // Core wraps from all ones: latch flips, status and irq follow
        xfer(1'b1, GTU_OFF_CNT, 32'hffff);
        xfer(1'b1, GTU_OFF_CTRL, 32'h2020);
        wt(1'b1);
        @(negedge hclk);
        chk("core_toggle_latch", 1'b1, latch);
        rd(GTU_OFF_STAT, 32'h1);
        @(negedge hclk);
        chk("irq", 1'b0, irq);
        xfer(1'b1, GTU_OFF_MASK, 32'h1);
        @(negedge hclk);
        chk("irq", 1'b1, irq);
        xfer(1'b1, GTU_OFF_STAT, 32'h1);
        @(negedge hclk);
        chk("irq", 1'b0, irq);
        // Latch moves only on a keyed write
        xfer(1'b1, GTU_OFF_CTRL, 32'h2020);
        @(negedge hclk);
        chk("core_toggle_latch", 1'b1, latch);
        xfer(1'b1, GTU_OFF_CTRL, 32'h22020);
        @(negedge hclk);
        chk("core_toggle_latch", 1'b0, latch);
        // Event counter from a random start
        seed = xs(seed);
        r = seed[15:0];
        xfer(1'b1, GTU_OFF_CNT + 8'h04, {16'h0, r});
        xfer(1'b1, GTU_OFF_CTRL + 8'h04, 32'h2022);
        gtu_pins_model_i.evt(5);
        repeat (20) @(posedge hclk);
        rd(GTU_OFF_CNT + 8'h04, {16'h0, r + 16'h5});
        // Quadrature position, four forward transitions
        xfer(1'b1, GTU_OFF_CTRL + 8'h08, 32'h2023);
        gtu_pins_model_i.quad(4);
        repeat (20) @(posedge hclk);
        rd(GTU_OFF_CNT + 8'h08, 32'h4);
        // Chained aux counts a latch edge and captures the down-wrapped core
        xfer(1'b1, GTU_OFF_CTRL + 8'h08, 32'h1720);
        xfer(1'b1, GTU_OFF_CNT, 32'h0);
        xfer(1'b1, GTU_OFF_CTRL, 32'h2060);
        wt(1'b1);
        rd(GTU_OFF_AUXR + 8'h08, 32'hffff);
        // Stopped core reloaded from aux 1 on a count pin edge
        xfer(1'b1, GTU_OFF_CTRL, 32'h2000);
        xfer(1'b1, GTU_OFF_AUXR + 8'h04, {16'h0, r});
        xfer(1'b1, GTU_OFF_CTRL + 8'h04, 32'ha800);
        gtu_pins_model_i.evt(1);
        rd(GTU_OFF_CNT, {16'h0, r});
        // Gated timer holds while its pin is low; one chained step kept
        xfer(1'b1, GTU_OFF_CTRL + 8'h08, 32'h2021);
        repeat (40) @(posedge hclk);
        rd(GTU_OFF_CNT + 8'h08, 32'h5);
        repeat (4) @(posedge hclk);
        end_of_test();
    end
endmodule : general_purpose_timer_unit_tb
